// ### tb/cvc_analog_model.sv
// behavioural comparator and input routing that face the control block
module cvc_analog_model (
  // controls from the block
  input  wire cvc_pkg::cvc_analog_ctrl_t analog_ctrl,
  input  wire logic [7:0]                ladder_level,
  // pin voltages in supply/96 steps
  input  wire logic [7:0]                pos_pin,
  input  wire logic [7:0]                neg_pin,
  // raw decision
  output logic                           cmp_raw
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] noninv_v;
  logic [7:0] inv_v;

  always_comb begin
    noninv_v = analog_ctrl.noninv_from_ref ? ladder_level : pos_pin;
    inv_v    = analog_ctrl.inv_from_pos_pin ? pos_pin : neg_pin;
    // a powered-down comparator gives no decision
    cmp_raw  = analog_ctrl.cmp_enable && (noninv_v > inv_v);
  end
endmodule : cvc_analog_model

// ### tb/cvc_top_test.sv
// register-level bench for comparator and reference control
module cvc_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                      clock;
  logic                      rst;
  logic                      ce;
  logic [7:0]                reg_addr;
  logic [7:0]                reg_wdata;
  logic                      reg_wr;
  logic                      reg_rd;
  logic [7:0]                reg_rdata;
  logic                      cmp_raw;
  cvc_pkg::cvc_analog_ctrl_t analog_ctrl;
  logic [7:0]                ladder_level;
  logic                      cmp_pin_out;
  logic [3:0]                analog_pin_choice;
  logic [2:0]                converter_clock_select;
  logic                      sleep_enter;
  logic                      sleeping;
  logic                      wake_request;
  logic                      irq;
  logic [7:0]                pos_pin;
  logic [7:0]                neg_pin;
  logic [7:0]                lvl;
  int                        n_fail;
  int                        checks;
  int                        k;

  cvc_top dut_u (.clock(clock), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmp_raw(cmp_raw), .analog_ctrl(analog_ctrl),
    .ladder_level(ladder_level), .cmp_pin_out(cmp_pin_out),
    .analog_pin_choice(analog_pin_choice),
    .converter_clock_select(converter_clock_select),
    .sleep_enter(sleep_enter), .sleeping(sleeping),
    .wake_request(wake_request), .irq(irq));

  cvc_analog_model model_u (.analog_ctrl(analog_ctrl),
    .ladder_level(ladder_level), .pos_pin(pos_pin), .neg_pin(neg_pin),
    .cmp_raw(cmp_raw));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= addr;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask : settle

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_enter = 1'b0;
    pos_pin = 8'h30;
    neg_pin = 8'h20;
    n_fail = 0;
    checks = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(cvc_pkg::CMP_CTRL_OFS, 8'h00);
    rd(cvc_pkg::REF_CTRL_OFS, 8'h00);
    rd(cvc_pkg::ANA_SEL_OFS, 8'h0F);
    rd(8'h55, 8'h00);
    wr(cvc_pkg::CMP_CTRL_OFS, 8'hFF);
    rd(cvc_pkg::CMP_CTRL_OFS, 8'h1F);
    chk_bit(analog_ctrl.cmp_enable, 1'b0);
    wr(cvc_pkg::ANA_SEL_OFS, 8'hFF);
    rd(cvc_pkg::ANA_SEL_OFS, 8'h7F);
    chk({5'h00, converter_clock_select}, 8'h07);
    chk({4'h0, analog_pin_choice}, 8'h0F);
    // every tap of both ranges
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 16; c++) begin
        wr(cvc_pkg::REF_CTRL_OFS, {2'b10, r[0], 1'b0, c[3:0]});
        settle();
        lvl = r[0] ? 8'(c * 4) : 8'(24 + c * 3);
        chk(ladder_level, lvl);
      end
    end
    wr(cvc_pkg::REF_CTRL_OFS, 8'h2F);
    settle();
    chk(ladder_level, 8'h00);
    chk_bit(analog_ctrl.ref_enable, 1'b0);
    // all mode codes, switch set then clear
    for (int m = 0; m < 8; m++) begin
      wr(cvc_pkg::CMP_CTRL_OFS, {5'h01, m[2:0]});
      settle();
      chk_bit(analog_ctrl.inv_from_pos_pin, m == 5 || m == 6);
      wr(cvc_pkg::CMP_CTRL_OFS, {5'h00, m[2:0]});
      settle();
      chk_bit(analog_ctrl.inv_from_pos_pin, 1'b0);
      chk_bit(analog_ctrl.cmp_enable, m != 0 && m != 7);
      chk_bit(analog_ctrl.noninv_from_ref, m >= 3 && m <= 6);
      chk_bit(analog_ctrl.out_pin_enable, m == 1 || m == 3 || m == 6);
    end
    // polarity with and without inversion, pins only
    for (int i = 0; i < 2; i++) begin
      wr(cvc_pkg::CMP_CTRL_OFS, {3'h0, i[0], 4'h1});
      pos_pin <= 8'h30;
      settle();
      chk_bit(cmp_pin_out, ~i[0]);
      rd(cvc_pkg::CMP_CTRL_OFS, {1'b0, ~i[0], 1'b0, i[0], 4'h1});
      @(posedge clock);
      pos_pin <= 8'h10;
      settle();
      chk_bit(cmp_pin_out, i[0]);
      rd(cvc_pkg::CMP_CTRL_OFS, {1'b0, i[0], 1'b0, i[0], 4'h1});
    end
    // reference 24 against pos 48 or neg 16
    @(posedge clock);
    pos_pin <= 8'h30;
    neg_pin <= 8'h10;
    wr(cvc_pkg::REF_CTRL_OFS, 8'h80);
    wr(cvc_pkg::CMP_CTRL_OFS, 8'h0D);
    settle();
    rd(cvc_pkg::CMP_CTRL_OFS, 8'h0D);
    wr(cvc_pkg::CMP_CTRL_OFS, 8'h05);
    settle();
    rd(cvc_pkg::CMP_CTRL_OFS, 8'h45);
    // change event with mask set, then masked
    wr(cvc_pkg::IRQ_MASK_OFS, 8'h01);
    wr(cvc_pkg::IRQ_STAT_OFS, 8'h01);
    settle();
    chk_bit(irq, 1'b0);
    wr(cvc_pkg::CMP_CTRL_OFS, 8'h0D);
    settle();
    chk_bit(irq, 1'b1);
    rd(cvc_pkg::IRQ_STAT_OFS, 8'h01);
    wr(cvc_pkg::IRQ_STAT_OFS, 8'h01);
    settle();
    chk_bit(irq, 1'b0);
    wr(cvc_pkg::IRQ_MASK_OFS, 8'h00);
    wr(cvc_pkg::CMP_CTRL_OFS, 8'h05);
    settle();
    chk_bit(irq, 1'b0);
    rd(cvc_pkg::IRQ_STAT_OFS, 8'h01);
    wr(cvc_pkg::IRQ_STAT_OFS, 8'h01);
    wr(cvc_pkg::IRQ_MASK_OFS, 8'h01);
    settle();
    chk_bit(irq, 1'b0);
    // sleep with comparator and reference on, wake on change
    @(posedge clock);
    sleep_enter <= 1'b1;
    @(posedge clock);
    sleep_enter <= 1'b0;
    #1;
    chk_bit(sleeping, 1'b1);
    settle();
    chk_bit(sleeping, 1'b1);
    chk_bit(analog_ctrl.cmp_enable, 1'b1);
    chk(ladder_level, 8'h18);
    @(posedge clock);
    neg_pin <= 8'h40;
    k = 0;
    while (wake_request !== 1'b1 && k < 10) begin
      @(posedge clock);
      #1;
      k++;
    end
    chk_bit(wake_request, 1'b1);
    chk_bit(sleeping, 1'b0);
    rd(cvc_pkg::CMP_CTRL_OFS, 8'h05);
    rd(cvc_pkg::REF_CTRL_OFS, 8'h80);
    // a write while the clock enable is low is not taken
    @(posedge clock);
    ce <= 1'b0;
    wr(cvc_pkg::REF_CTRL_OFS, 8'h00);
    ce <= 1'b1;
    rd(cvc_pkg::REF_CTRL_OFS, 8'h80);
    // reset in mid-run
    wr(cvc_pkg::ANA_SEL_OFS, 8'h00);
    settle();
    chk({4'h0, analog_pin_choice}, 8'h00);
    chk({5'h00, converter_clock_select}, 8'h00);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk_bit(analog_ctrl.ref_enable, 1'b0);
    chk_bit(analog_ctrl.cmp_enable, 1'b0);
    chk({4'h0, analog_pin_choice}, 8'h0F);
    rd(cvc_pkg::CMP_CTRL_OFS, 8'h00);
    rd(cvc_pkg::REF_CTRL_OFS, 8'h00);
    rd(cvc_pkg::ANA_SEL_OFS, 8'h0F);
    rd(cvc_pkg::IRQ_MASK_OFS, 8'h00);
    end_sim();
  end
endmodule : cvc_top_test

// ### verilog/cvc_pkg.sv
// constants, types and helpers for comparator and reference control
package cvc_pkg;

  // register offsets
  localparam logic [7:0] CMP_CTRL_OFS  = 8'h19;
  localparam logic [7:0] ANA_SEL_OFS   = 8'h9F;
  localparam logic [7:0] REF_CTRL_OFS  = 8'h99;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h8C;

  // reset values
  localparam logic [7:0] CMP_CTRL_RST  = 8'h00;
  localparam logic [7:0] REF_CTRL_RST  = 8'h00;
  localparam logic [7:0] ANA_SEL_RST   = 8'h0F;
  localparam logic [7:0] IRQ_STAT_RST  = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST  = 8'h00;

  // writable bits of each register
  localparam logic [7:0] CMP_CTRL_WMASK = 8'h1F;
  localparam logic [7:0] REF_CTRL_WMASK = 8'hAF;
  localparam logic [7:0] ANA_SEL_WMASK  = 8'h7F;
  localparam logic [7:0] IRQ_WMASK      = 8'h01;

  // field positions
  localparam int CMP_RESULT_BIT = 6;
  localparam int CMP_INVERT_BIT = 4;
  localparam int CMP_SWITCH_BIT = 3;
  localparam int CMP_MODE_LSB   = 0;
  localparam int MODE_W         = 3;
  localparam int REF_ENABLE_BIT = 7;
  localparam int REF_RANGE_BIT  = 5;
  localparam int REF_LEVEL_LSB  = 0;
  localparam int LEVEL_CODE_W   = 4;
  localparam int ANA_CLK_LSB    = 4;
  localparam int ANA_CLK_W      = 3;
  localparam int ANA_PIN_LSB    = 0;
  localparam int ANA_PIN_W      = 4;
  localparam int IRQ_CHANGE_BIT = 0;

  // comparator mode codes
  localparam logic [2:0] MODE_RESET      = 3'h0;
  localparam logic [2:0] MODE_PIN_OUT    = 3'h1;
  localparam logic [2:0] MODE_PIN_NOOUT  = 3'h2;
  localparam logic [2:0] MODE_REF_OUT    = 3'h3;
  localparam logic [2:0] MODE_REF_NOOUT  = 3'h4;
  localparam logic [2:0] MODE_REF_SW     = 3'h5;
  localparam logic [2:0] MODE_REF_SW_OUT = 3'h6;
  localparam logic [2:0] MODE_OFF        = 3'h7;

  // ladder output in steps of supply / 96 (common multiple of 24 and 32)
  localparam logic [7:0] LOW_STEP   = 8'h04;
  localparam logic [7:0] HIGH_STEP  = 8'h03;
  localparam logic [7:0] HIGH_BASE  = 8'h18;

  typedef struct packed {
    logic       cmp_enable;
    logic       noninv_from_ref;
    logic       inv_from_pos_pin;
    logic       out_pin_enable;
    logic       ref_enable;
    logic       ref_range_low;
    logic [3:0] ref_level_code;
  } cvc_analog_ctrl_t;

  typedef enum logic [1:0] {
    ST_AWAKE  = 2'b01,
    ST_ASLEEP = 2'b10
  } cvc_power_state_t;

  function automatic logic cvc_mode_uses_ref(input logic [2:0] mode);
    return (mode == MODE_REF_OUT) || (mode == MODE_REF_NOOUT) ||
           (mode == MODE_REF_SW) || (mode == MODE_REF_SW_OUT);
  endfunction : cvc_mode_uses_ref

  function automatic logic cvc_mode_on(input logic [2:0] mode);
    return (mode != MODE_RESET) && (mode != MODE_OFF);
  endfunction : cvc_mode_on

  function automatic logic cvc_mode_switched(input logic [2:0] mode);
    return (mode == MODE_REF_SW) || (mode == MODE_REF_SW_OUT);
  endfunction : cvc_mode_switched

endpackage : cvc_pkg

// ### verilog/cvc_ref_ladder.sv
// ladder tap selection: reference level in steps of supply / 96
module cvc_ref_ladder #(
  parameter int LEVEL_W = 8
) (
  // control
  input  wire logic               ref_enable,
  input  wire logic               range_low,
  input  wire logic [3:0]         level_code,
  // tap
  output logic      [LEVEL_W-1:0] level
);

  // the widest tap, 24 + 15 * 3, needs seven bits
  if (LEVEL_W < 7) begin : g_level_w_check
    $error("cvc_ref_ladder: LEVEL_W must be at least 7");
  end

  logic [7:0] code_w;
  logic [7:0] tap;

  assign code_w = {4'h0, level_code};

  always_comb begin
    tap = 8'h00;
    if (ref_enable) begin
      if (range_low) begin
        tap = 8'(code_w * cvc_pkg::LOW_STEP);
      end else begin
        tap = 8'(cvc_pkg::HIGH_BASE + code_w * cvc_pkg::HIGH_STEP);
      end
    end
  end

  assign level = LEVEL_W'(tap);

endmodule : cvc_ref_ladder

// ### verilog/cvc_top.sv
// comparator and ladder reference control with register file
module cvc_top #(
  parameter int LEVEL_W = 8
) (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    ce,
  // register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  // analog comparator
  input  wire logic                    cmp_raw,
  output cvc_pkg::cvc_analog_ctrl_t    analog_ctrl,
  output logic      [LEVEL_W-1:0]      ladder_level,
  output logic                         cmp_pin_out,
  // shared pins
  output logic      [3:0]              analog_pin_choice,
  output logic      [2:0]              converter_clock_select,
  // power
  input  wire logic                    sleep_enter,
  output logic                         sleeping,
  output logic                         wake_request,
  // interrupt
  output logic                         irq
);

  // the widest tap, 24 + 15 * 3, needs seven bits
  if (LEVEL_W < 7) begin : g_level_w_check
    $error("cvc_top: LEVEL_W must be at least 7");
  end

  logic [7:0]                cmp_ctrl_reg;
  logic [7:0]                ref_ctrl_reg;
  logic [7:0]                ana_sel_reg;
  logic [7:0]                irq_stat_reg;
  logic [7:0]                irq_mask_reg;
  logic                      compare_result_reg;
  logic                      compare_result_next;
  logic [7:0]                rdata_next;
  logic                      change_event;
  logic                      wake_cond;
  logic [LEVEL_W-1:0]        ladder_tap;
  logic [2:0]                compare_mode_select;
  logic                      result_invert;
  logic                      input_route_switch;
  cvc_pkg::cvc_analog_ctrl_t analog_next;
  cvc_pkg::cvc_power_state_t state_reg;

  assign compare_mode_select = cmp_ctrl_reg[cvc_pkg::CMP_MODE_LSB +:
                                            cvc_pkg::MODE_W];
  assign result_invert       = cmp_ctrl_reg[cvc_pkg::CMP_INVERT_BIT];
  assign input_route_switch  = cmp_ctrl_reg[cvc_pkg::CMP_SWITCH_BIT];

  // control registers; sleep and wake never touch them
  always_ff @(posedge clock) begin
    if (rst) begin
      cmp_ctrl_reg <= cvc_pkg::CMP_CTRL_RST;
      ref_ctrl_reg <= cvc_pkg::REF_CTRL_RST;
      ana_sel_reg  <= cvc_pkg::ANA_SEL_RST;
      irq_mask_reg <= cvc_pkg::IRQ_MASK_RST;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        cvc_pkg::CMP_CTRL_OFS: begin
          cmp_ctrl_reg <= reg_wdata & cvc_pkg::CMP_CTRL_WMASK;
        end
        cvc_pkg::REF_CTRL_OFS: begin
          ref_ctrl_reg <= reg_wdata & cvc_pkg::REF_CTRL_WMASK;
        end
        cvc_pkg::ANA_SEL_OFS: begin
          ana_sel_reg <= reg_wdata & cvc_pkg::ANA_SEL_WMASK;
        end
        cvc_pkg::IRQ_MASK_OFS: begin
          irq_mask_reg <= reg_wdata & cvc_pkg::IRQ_WMASK;
        end
        default: begin
        end
      endcase
    end
  end

  // result with polarity applied; held low while the comparator is off
  always_comb begin
    compare_result_next = 1'b0;
    if (cvc_pkg::cvc_mode_on(compare_mode_select)) begin
      compare_result_next = cmp_raw ^ result_invert;
    end
  end

  assign change_event = cvc_pkg::cvc_mode_on(compare_mode_select) &&
                        (compare_result_next != compare_result_reg);

  always_ff @(posedge clock) begin
    if (rst) begin
      compare_result_reg <= 1'b0;
    end else if (ce) begin
      compare_result_reg <= compare_result_next;
    end
  end

  // sticky change flag; a new event beats a write-one clear
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_stat_reg <= cvc_pkg::IRQ_STAT_RST;
    end else if (ce) begin
      if (change_event) begin
        irq_stat_reg[cvc_pkg::IRQ_CHANGE_BIT] <= 1'b1;
      end else if (reg_wr && reg_addr == cvc_pkg::IRQ_STAT_OFS &&
                   reg_wdata[cvc_pkg::IRQ_CHANGE_BIT]) begin
        irq_stat_reg[cvc_pkg::IRQ_CHANGE_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // analog control derived from the mode field, the switch bit and the reference register
  always_comb begin
    analog_next                  = '0;
    analog_next.cmp_enable       = cvc_pkg::cvc_mode_on(compare_mode_select);
    analog_next.noninv_from_ref  =
      cvc_pkg::cvc_mode_uses_ref(compare_mode_select);
    analog_next.inv_from_pos_pin =
      cvc_pkg::cvc_mode_switched(compare_mode_select) &&
      input_route_switch;
    analog_next.out_pin_enable   =
      (compare_mode_select == cvc_pkg::MODE_PIN_OUT) ||
      (compare_mode_select == cvc_pkg::MODE_REF_OUT) ||
      (compare_mode_select == cvc_pkg::MODE_REF_SW_OUT);
    analog_next.ref_enable       =
      ref_ctrl_reg[cvc_pkg::REF_ENABLE_BIT];
    analog_next.ref_range_low    = ref_ctrl_reg[cvc_pkg::REF_RANGE_BIT];
    analog_next.ref_level_code   =
      ref_ctrl_reg[cvc_pkg::REF_LEVEL_LSB +: cvc_pkg::LEVEL_CODE_W];
  end

  cvc_ref_ladder #(
    .LEVEL_W (LEVEL_W)
  ) u_ladder (
    .ref_enable (analog_next.ref_enable),
    .range_low  (analog_next.ref_range_low),
    .level_code (analog_next.ref_level_code),
    .level      (ladder_tap)
  );

  // analog outputs ignore the power state so both stay on in sleep
  always_ff @(posedge clock) begin
    if (rst) begin
      analog_ctrl  <= '0;
      ladder_level <= '0;
      cmp_pin_out  <= 1'b0;
    end else if (ce) begin
      analog_ctrl  <= analog_next;
      ladder_level <= ladder_tap;
      cmp_pin_out  <= analog_next.out_pin_enable & compare_result_next;
    end
  end

  // shared pin selection; drivers on analog pins are software's job
  always_ff @(posedge clock) begin
    if (rst) begin
      analog_pin_choice      <= cvc_pkg::ANA_SEL_RST[3:0];
      converter_clock_select <= cvc_pkg::ANA_SEL_RST[6:4];
    end else if (ce) begin
      analog_pin_choice      <= ana_sel_reg[cvc_pkg::ANA_PIN_LSB +:
                                            cvc_pkg::ANA_PIN_W];
      converter_clock_select <= ana_sel_reg[cvc_pkg::ANA_CLK_LSB +:
                                            cvc_pkg::ANA_CLK_W];
    end
  end

  // sleep and wake sequencing
  assign wake_cond = analog_ctrl.cmp_enable && irq;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg    <= cvc_pkg::ST_AWAKE;
      sleeping     <= 1'b0;
      wake_request <= 1'b0;
    end else if (ce) begin
      wake_request <= 1'b0;
      unique case (state_reg)
        cvc_pkg::ST_AWAKE: begin
          if (sleep_enter) begin
            state_reg <= cvc_pkg::ST_ASLEEP;
            sleeping  <= 1'b1;
          end
        end
        cvc_pkg::ST_ASLEEP: begin
          if (wake_cond) begin
            state_reg    <= cvc_pkg::ST_AWAKE;
            sleeping     <= 1'b0;
            wake_request <= 1'b1;
          end
        end
      endcase
    end
  end

  // read data one cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      cvc_pkg::CMP_CTRL_OFS: begin
        rdata_next = cmp_ctrl_reg & cvc_pkg::CMP_CTRL_WMASK;
        rdata_next[cvc_pkg::CMP_RESULT_BIT] = compare_result_reg;
      end
      cvc_pkg::REF_CTRL_OFS: begin
        rdata_next = ref_ctrl_reg & cvc_pkg::REF_CTRL_WMASK;
      end
      cvc_pkg::ANA_SEL_OFS: begin
        rdata_next = ana_sel_reg & cvc_pkg::ANA_SEL_WMASK;
      end
      cvc_pkg::IRQ_STAT_OFS: begin
        rdata_next = irq_stat_reg & cvc_pkg::IRQ_WMASK;
      end
      cvc_pkg::IRQ_MASK_OFS: begin
        rdata_next = irq_mask_reg & cvc_pkg::IRQ_WMASK;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end
  end

  chk_result_polarity: assert property (
    @(posedge clock) disable iff (rst)
    ce && cvc_pkg::cvc_mode_on(compare_mode_select)
    |=> compare_result_reg == ($past(cmp_raw) ^ $past(result_invert))
  ) else $error("result polarity wrong");

  chk_invert_flips: assert property (
    @(posedge clock) disable iff (rst)
    ce && cvc_pkg::cvc_mode_on(compare_mode_select) && result_invert
    && cmp_raw |=> !compare_result_reg
  ) else $error("inverted result not low");

  chk_switch_route: assert property (
    @(posedge clock) disable iff (rst)
    ce |=> analog_ctrl.inv_from_pos_pin ==
      ($past(compare_mode_select) inside {3'h5, 3'h6} &&
       $past(input_route_switch))
  ) else $error("input switch routing wrong");

  chk_ref_modes: assert property (
    @(posedge clock) disable iff (rst)
    ce |=> analog_ctrl.noninv_from_ref ==
      ($past(compare_mode_select) inside {3'h3, 3'h4, 3'h5, 3'h6})
  ) else $error("reference mode decode wrong");

  chk_off_mode: assert property (
    @(posedge clock) disable iff (rst)
    ce && compare_mode_select == 3'h7 |=> !analog_ctrl.cmp_enable
      && !cmp_pin_out
  ) else $error("comparator not off in mode 7");

  chk_ref_enable: assert property (
    @(posedge clock) disable iff (rst)
    ce |=> analog_ctrl.ref_enable == $past(ref_ctrl_reg[7])
  ) else $error("reference enable does not follow bit 7");

  chk_sleep_keeps: assert property (
    @(posedge clock) disable iff (rst)
    sleeping && ce && !reg_wr ##1 ce |=> $stable(analog_ctrl)
  ) else $error("analog control changed during sleep");

  chk_wake_irq: assert property (
    @(posedge clock) disable iff (rst)
    ce && sleeping && analog_ctrl.cmp_enable && irq
    |=> wake_request && !sleeping
  ) else $error("comparator interrupt did not wake");

  chk_wake_regs: assert property (
    @(posedge clock) disable iff (rst)
    wake_request && !$past(reg_wr)
    |-> $stable(cmp_ctrl_reg) && $stable(ref_ctrl_reg)
  ) else $error("wake changed control registers");

  chk_reset_values: assert property (
    @(posedge clock) disable iff (rst)
    $past(rst) |-> cmp_ctrl_reg == 8'h00 && ref_ctrl_reg == 8'h00
      && ana_sel_reg == 8'h0F && !analog_ctrl.ref_enable
  ) else $error("reset values wrong");

  chk_ladder_level: assert property (
    @(posedge clock) disable iff (rst)
    ce && analog_next.ref_enable |=> ladder_level == LEVEL_W'(
      $past(analog_next.ref_range_low)
        ? 8'($past(analog_next.ref_level_code)) * 8'h04
        : 8'h18 + 8'($past(analog_next.ref_level_code)) * 8'h03)
  ) else $error("ladder level wrong");

  chk_readonly_bits: assert property (
    @(posedge clock) disable iff (rst)
    ce && reg_rd && reg_addr == 8'h19 |=> reg_rdata[7] == 1'b0
      && reg_rdata[5] == 1'b0 && reg_rdata[6] == $past(compare_result_reg)
  ) else $error("control register read-only bits wrong");

  chk_sticky_set: assert property (
    @(posedge clock) disable iff (rst)
    ce && change_event |=> irq_stat_reg[0]
  ) else $error("change event lost");

  chk_irq_level: assert property (
    @(posedge clock) disable iff (rst)
    ce |=> irq == |($past(irq_stat_reg) & $past(irq_mask_reg))
  ) else $error("interrupt level wrong");

  chk_result_off: assert property (
    @(posedge clock) disable iff (rst)
    ce && !cvc_pkg::cvc_mode_on(compare_mode_select)
    |=> !compare_result_reg
  ) else $error("result not low while comparator off");

  chk_rdata_idle: assert property (
    @(posedge clock) disable iff (rst)
    ce && !reg_rd |=> reg_rdata == 8'h00
  ) else $error("read data not zero outside a read");

endmodule : cvc_top
